// file: verilog/tsp_cfg.svh
// Constants for the serial temperature sensor port.
// Assumes it is included by bare name from every design file that needs it.
`ifndef TSP_CFG_SVH
`define TSP_CFG_SVH

// ****************************************
// Timing
// ****************************************
`define TSP_CLK_HZ 50000000
`define TSP_CONV_TIME_MS 300
`define TSP_CONV_CYC (`TSP_CONV_TIME_MS * (`TSP_CLK_HZ / 1000))
`define TSP_CONV_CNT_W 24

// ****************************************
// Word layout
// ****************************************
`define TSP_WORD_W 16
`define TSP_TEMP_W 13
`define TSP_ID_W 8
`define TSP_TEMP_RST 13'h0000
`define TSP_WORD_RST 16'h0000
`define TSP_UNDEF_BITS 2'h0
`define TSP_ID_LOW 8'h00
`define TSP_DRIVEN_BITS 4'hE
`define TSP_MSB_POS 4'hF

// ****************************************
// Frame sequencing
// ****************************************
`define TSP_RCNT_W 7
`define TSP_RCNT_ZERO 7'h00
`define TSP_RCNT_ONE 7'h01
`define TSP_RCNT_SAT 7'h40
`define TSP_BLK_TEMP 3'h0
`define TSP_BLK_ID 3'h2
`define TSP_BYTE_LAST 4'h7
`define TSP_WORD_LAST 4'hF

// ****************************************
// Mode codes
// ****************************************
`define TSP_CODE_SHDN 8'hFF
`define TSP_CODE_RUN 8'h00
// Identification value is arbitrary
`define TSP_ID_DEFAULT 8'h3C

`endif

// file: verilog/tsp_pkg.sv
// Types shared by the serial temperature sensor port.
// Assumes nothing of its surroundings.
package tsp_pkg;

  typedef enum logic [1:0] {
    TSP_CV_IDLE = 2'h0,
    TSP_CV_RUN = 2'h1
  } tsp_conv_e;

  typedef enum logic {
    TSP_MODE_CONT = 1'h0,
    TSP_MODE_SHDN = 1'h1
  } tsp_mode_e;

endpackage : tsp_pkg

// file: verilog/tsp_sync.sv
// Two-stage synchroniser for levels entering the system clock domain.
// Assumes each bit is a level or a toggle held for several clocks.
`timescale 1ns/1ps
module tsp_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule : tsp_sync

// file: verilog/tsp_port.sv
// Serial readout and mode control of a digital temperature sensor.
// Assumes a bus master drives chip select, serial clock and data pin;
// the converter delivers a code on i_temp_code in the i_clk domain.
`timescale 1ns/1ps
`include "tsp_cfg.svh"

module tsp_port
  import tsp_pkg::*;
#(
  parameter int CONV_CYC = `TSP_CONV_CYC,
  parameter int CNT_W = `TSP_CONV_CNT_W,
  parameter logic [`TSP_ID_W-1:0] ID_CODE = `TSP_ID_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_sio,
  output logic o_sio,
  output logic o_sio_oe_n,
  input wire logic [`TSP_TEMP_W-1:0] i_temp_code,
  output logic o_shutdown,
  output logic o_first_done,
  output logic o_conv_busy,
  output logic o_conv_done
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);

  // System domain
  logic lnk_rst_reg;
  logic cs_n_s;
  logic tgl_s;
  logic tgl_seen_reg;
  tsp_mode_e mode_reg;
  tsp_conv_e conv_st_reg;
  logic [CNT_W-1:0] conv_cnt_reg;
  logic conv_end;
  logic [`TSP_TEMP_W-1:0] temp_reg;
  logic first_done_reg;
  logic [`TSP_WORD_W-1:0] snap_reg;
  logic busy_reg;
  logic done_reg;

  // Link domain, rising edge
  logic [`TSP_RCNT_W-1:0] rcnt_reg;
  logic [`TSP_WORD_W-1:0] rx_reg;
  logic frame_sd_reg;
  logic cfg_tgl_reg;
  logic cfg_sd_reg;
  logic wr_phase;
  logic [7:0] low_byte;
  logic commit_run;
  logic commit_full;

  // Link domain, falling edge
  logic fall_seen_reg;
  logic dout_reg;
  logic doe_n_reg;
  logic [3:0] bit_k;
  logic [3:0] bit_pos;
  logic rd_temp;
  logic rd_id;
  logic in_data;
  logic [`TSP_WORD_W-1:0] id_word;
  logic dout_next;
  logic doe_n_next;

  // ****************************************
  // Crossings into the system clock
  // ****************************************
  // Registered copy of reset, used as the link's asynchronous clear;
  // the serial clock may be stopped, so no synchronous reset reaches it.
  always_ff @(posedge i_clk) begin
    lnk_rst_reg <= i_rst;
  end

  tsp_sync #(
    .W(2),
    .RST_VAL(2'h1)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({cfg_tgl_reg, i_cs_n}),
    .o_sync({tgl_s, cs_n_s})
  );

  // ****************************************
  // Mode register
  // ****************************************
  // cfg_sd_reg is stable for many serial clocks after each toggle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_reg <= TSP_MODE_CONT;
      tgl_seen_reg <= 1'h0;
    end else begin
      tgl_seen_reg <= tgl_s;
      if (tgl_s != tgl_seen_reg) begin
        mode_reg <= tsp_mode_e'(cfg_sd_reg);
      end
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  assign conv_end = (conv_st_reg == TSP_CV_RUN) &&
                    (conv_cnt_reg == CONV_LAST);

  // A conversion in flight always completes, selected or not
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      conv_st_reg <= TSP_CV_RUN;
      conv_cnt_reg <= '0;
    end else begin
      case (conv_st_reg)
        TSP_CV_RUN: begin
          if (conv_cnt_reg == CONV_LAST) begin
            conv_cnt_reg <= '0;
            if (mode_reg == TSP_MODE_SHDN) begin
              conv_st_reg <= TSP_CV_IDLE;
            end
          end else begin
            conv_cnt_reg <= conv_cnt_reg + CNT_W'(1);
          end
        end
        TSP_CV_IDLE: begin
          conv_cnt_reg <= '0;
          if (mode_reg == TSP_MODE_CONT) begin
            conv_st_reg <= TSP_CV_RUN;
          end
        end
        default: begin
          conv_st_reg <= TSP_CV_IDLE;
          conv_cnt_reg <= '0;
        end
      endcase
    end
  end

  // ****************************************
  // Result and first-conversion flag
  // ****************************************
  // Result only changes at a conversion end, so shutdown keeps it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      temp_reg <= `TSP_TEMP_RST;
    end else if (conv_end) begin
      temp_reg <= i_temp_code;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      first_done_reg <= 1'h0;
    end else if (conv_end) begin
      first_done_reg <= 1'h1;
    end
  end

  // ****************************************
  // Output shift word
  // ****************************************
  // Loaded only while deselected: the link reads it without a
  // crossing because it never moves during a frame. A result that
  // lands mid-frame is picked up once the frame ends.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      snap_reg <= `TSP_WORD_RST;
    end else if (cs_n_s) begin
      snap_reg <= {temp_reg, first_done_reg, `TSP_UNDEF_BITS};
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_reg <= 1'h0;
      done_reg <= 1'h0;
    end else begin
      busy_reg <= (conv_st_reg == TSP_CV_RUN);
      done_reg <= conv_end;
    end
  end

  assign o_shutdown = mode_reg;
  assign o_first_done = first_done_reg;
  assign o_conv_busy = busy_reg;
  assign o_conv_done = done_reg;

  // ****************************************
  // Link: bit counting and configuration input
  // ****************************************
  // Blocks of sixteen rising edges: temperature out, config in,
  // identification out if the first config block wrote shutdown, config in; beyond that the link idles.
  assign wr_phase = rcnt_reg[4] && !rcnt_reg[6];
  assign low_byte = {rx_reg[6:0], i_sio};
  assign commit_run = wr_phase && (rcnt_reg[3:0] == `TSP_BYTE_LAST) &&
                      (low_byte == `TSP_CODE_RUN);
  assign commit_full = wr_phase && (rcnt_reg[3:0] == `TSP_WORD_LAST);

  // Held cleared while deselected, so stray clocks do nothing
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      rcnt_reg <= `TSP_RCNT_ZERO;
      rx_reg <= `TSP_WORD_RST;
      frame_sd_reg <= 1'h0;
    end else begin
      if (rcnt_reg != `TSP_RCNT_SAT) begin
        rcnt_reg <= rcnt_reg + `TSP_RCNT_ONE;
      end
      if (wr_phase) begin
        rx_reg <= {rx_reg[`TSP_WORD_W-2:0], i_sio};
      end
      if (commit_full) begin
        frame_sd_reg <= (low_byte == `TSP_CODE_SHDN);
      end else if (commit_run) begin
        frame_sd_reg <= 1'h0;
      end
    end
  end

  // Survives deselect; a short eight-bit zero write resumes early
  always_ff @(posedge i_sck or posedge lnk_rst_reg) begin
    if (lnk_rst_reg) begin
      cfg_tgl_reg <= 1'h0;
      cfg_sd_reg <= 1'h0;
    end else if (commit_full || commit_run) begin
      cfg_tgl_reg <= ~cfg_tgl_reg;
      cfg_sd_reg <= commit_full && (low_byte == `TSP_CODE_SHDN);
    end
  end

  // ****************************************
  // Link: serial output
  // ****************************************
  assign id_word = {ID_CODE, `TSP_ID_LOW};
  assign bit_k = rcnt_reg[3:0];
  assign bit_pos = `TSP_MSB_POS - bit_k;
  assign rd_temp = (rcnt_reg[6:4] == `TSP_BLK_TEMP);
  assign rd_id = (rcnt_reg[6:4] == `TSP_BLK_ID) && frame_sd_reg;
  assign in_data = (bit_k < `TSP_DRIVEN_BITS);

  always_comb begin
    dout_next = rd_temp ? snap_reg[bit_pos] : id_word[bit_pos];
    doe_n_next = !((rd_temp || rd_id) && in_data);
  end

  // Next bit follows each falling edge of the serial clock
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      fall_seen_reg <= 1'h0;
      dout_reg <= 1'h0;
      doe_n_reg <= 1'h1;
    end else begin
      fall_seen_reg <= 1'h1;
      dout_reg <= dout_next;
      doe_n_reg <= doe_n_next;
    end
  end

  // Sign bit must appear with select alone, before any clock edge,
  // which costs a small mux behind the flops.
  assign o_sio = fall_seen_reg ? dout_reg : snap_reg[`TSP_MSB_POS];
  assign o_sio_oe_n = i_cs_n || (fall_seen_reg && doe_n_reg);

endmodule : tsp_port

// file: tb/tsp_port_monitor.sv
// Checker for the sensor port, watching its top-level ports.
// Assumes CONV_CYC is handed on by the bind below.
`timescale 1ns/1ps
module tsp_port_monitor #(
  parameter int CONV_CYC = 50
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic o_sio,
  input wire logic o_sio_oe_n,
  input wire logic o_shutdown,
  input wire logic o_first_done,
  input wire logic o_conv_busy,
  input wire logic o_conv_done
);
  localparam int HI = CONV_CYC + 3;
  logic [6:0] rise_reg;
  // Rises already seen in this frame
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      rise_reg <= 7'h00;
    end else if (rise_reg != 7'h7F) begin
      rise_reg <= rise_reg + 7'h01;
    end
  end
  AST_OE_IDLE:
    assert property (@(posedge i_clk) disable iff (i_rst)
      i_cs_n |-> o_sio_oe_n) else $error("line driven when idle");
  AST_RST_VAL:
    assert property (@(posedge i_clk) disable iff (i_rst)
      $fell(i_rst) |-> !o_shutdown && !o_first_done && !o_conv_done)
      else $error("bad state after reset");
  AST_DONE_GAP:
    assert property (@(posedge i_clk) disable iff (i_rst)
      o_conv_done |=> !o_conv_done [*8]) else $error("done too soon");
  AST_CONV_NEXT:
    assert property (@(posedge i_clk) disable iff (i_rst)
      o_conv_done && !o_shutdown |-> ##[1:HI] (o_conv_done || o_shutdown))
      else $error("conversion stalled");
  AST_FIRST_SET:
    assert property (@(posedge i_clk) disable iff (i_rst)
      o_conv_done |-> o_first_done) else $error("flag not set");
  AST_FIRST_HOLD:
    assert property (@(posedge i_clk) disable iff (i_rst)
      o_first_done |=> o_first_done) else $error("flag dropped");
  AST_SHDN_QUIET:
    assert property (@(posedge i_clk) disable iff (i_rst)
      o_shutdown && !o_conv_busy |=> !o_conv_done)
      else $error("conversion in shutdown");
  AST_TEMP_DRIVEN:
    assert property (@(posedge i_sck) disable iff (i_cs_n)
      rise_reg < 7'h0E |-> !o_sio_oe_n) else $error("bit released");
  AST_RELEASE:
    assert property (@(posedge i_sck) disable iff (i_cs_n)
      (rise_reg >= 7'h0E && rise_reg < 7'h20) || rise_reg >= 7'h2E
      |-> o_sio_oe_n) else $error("line not released");
  AST_ID_ZERO:
    assert property (@(posedge i_sck) disable iff (i_cs_n)
      rise_reg >= 7'h28 && rise_reg < 7'h2E && !o_sio_oe_n |-> !o_sio)
      else $error("id low bits not zero");
  COV_DONE: cover property (@(posedge i_clk) o_conv_done);
  COV_SHDN: cover property (@(posedge i_clk) $rose(o_shutdown));
  COV_LONG: cover property (@(posedge i_sck) rise_reg == 7'h3F);
endmodule : tsp_port_monitor

bind tsp_port tsp_port_monitor #(.CONV_CYC(CONV_CYC)) u_mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_sck(i_sck), .i_cs_n(i_cs_n),
  .o_sio(o_sio), .o_sio_oe_n(o_sio_oe_n), .o_shutdown(o_shutdown),
  .o_first_done(o_first_done), .o_conv_busy(o_conv_busy),
  .o_conv_done(o_conv_done));

// file: tb/tsp_master_model.sv
// Serial bus master: frames of up to 64 clocks, MSB first.
// Assumes the bench mixes its data with the device's on the wire.
`timescale 1ns/1ps
module tsp_master_model (
  output logic sck,
  output logic cs_n,
  output logic sio,
  input wire logic dev_sio,
  input wire logic dev_oe_n
);
  logic [63:0] rd;
  event done;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sio = 1'b0;
  end
  // Clock stands still outside frames
  task automatic xfer(input int n, input logic [63:0] wr);
    rd = {64{1'bz}};
    cs_n = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      sio = wr[63-i];
      #3 sck = 1'b1;
      rd[63-i] = dev_oe_n ? 1'bz : dev_sio;
      #3 sck = 1'b0;
    end
    #100 cs_n = 1'b1;
    sio = ~sio;
    -> done;
  endtask : xfer
endmodule : tsp_master_model

// file: tb/tsp_port_tb_top.sv
// Testbench for the sensor port: reads, mode writes, id reads.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
module tsp_port_tb_top;
  localparam int CONV = 50;
  // Identification value is arbitrary
  localparam logic [7:0] IDC = 8'hA5;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [12:0] i_temp_code = 13'h0000;
  logic [12:0] tcur = 13'h0000;
  logic f = 1'b0;
  logic sck, cs_n, m_sio, o_sio, oe_n, sio_w;
  logic o_shutdown, o_first_done, o_conv_busy, o_conv_done;
  logic [7:0] codes [9] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0F, 8'h1F,
    8'h3F, 8'h7F, 8'hFF};
  logic [63:0] exp_q [$];
  int err_total = 0;
  int compares = 0;
  always #10 i_clk = ~i_clk;
  assign sio_w = oe_n ? m_sio : o_sio;
  tsp_port #(.CONV_CYC(CONV), .ID_CODE(IDC)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n),
    .i_sio(sio_w), .o_sio(o_sio), .o_sio_oe_n(oe_n),
    .i_temp_code(i_temp_code), .o_shutdown(o_shutdown),
    .o_first_done(o_first_done), .o_conv_busy(o_conv_busy),
    .o_conv_done(o_conv_done));
  tsp_master_model mst (.sck(sck), .cs_n(cs_n), .sio(m_sio),
    .dev_sio(o_sio), .dev_oe_n(oe_n));
  task automatic end_sim();
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic chk_word(input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t frame %h exp %h", $time, g, e);
    end
  endtask : chk_word
  task automatic chk_bit(input logic e, input logic g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t level %b exp %b", $time, g, e);
    end
  endtask : chk_bit
  task automatic clks(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : clks
  task automatic wait_done();
    int k;
    k = 0;
    while (o_conv_done !== 1'b1) begin
      clks(1);
      k++;
      if (k > 3 * CONV) begin
        err_total++;
        $display("BAD %0t no conversion", $time);
        end_sim();
      end
    end
    clks(1);
  endtask : wait_done
  // Idle frame positions read back as released
  task automatic frame(input int n, input logic [15:0] c1,
      input logic [15:0] c2, input logic id_ok);
    logic [63:0] wr;
    logic [63:0] e;
    wr = {$urandom, $urandom};
    wr[47:32] = c1;
    wr[15:0] = c2;
    e = {tcur, f, 2'bzz, {48{1'bz}}};
    if (id_ok) e[31:16] = {IDC, 6'h00, 2'bzz};
    for (int i = n; i < 64; i++) e[63-i] = 1'bz;
    clks(5);
    exp_q.push_back(e);
    mst.xfer(n, wr);
    clks(1);
  endtask : frame
  always @(mst.done) begin
    if (exp_q.size() > 0) chk_word(exp_q.pop_front(), mst.rd);
  end
  initial begin
    void'($urandom(32'hDEA5A01C));
    clks(10);
    i_rst = 1'b0;
    frame(16, 16'h0000, 16'h0000, 1'b0);
    chk_bit(1'b0, o_first_done);
    for (int i = 0; i < 5; i++) begin
      tcur = (i == 0) ? 13'h1000 : 13'($urandom);
      i_temp_code = tcur;
      wait_done();
      wait_done();
      f = 1'b1;
      frame((i == 4) ? 4 : 16, 16'h0000, 16'h0000, 1'b0);
    end
    foreach (codes[i]) begin
      frame(64, {8'($urandom), 8'hFF}, {8'($urandom), codes[i]},
        1'b1);
      clks(5);
      chk_bit(codes[i] == 8'hFF, o_shutdown);
    end
    clks(2 * CONV);
    i_temp_code = tcur ^ 13'h1555;
    clks(2 * CONV);
    chk_bit(1'b0, o_conv_busy);
    frame(56, {8'($urandom), 8'hFF}, 16'h0000, 1'b1);
    chk_bit(1'b0, o_shutdown);
    tcur = i_temp_code;
    wait_done();
    wait_done();
    frame(48, 16'h0000, 16'h0000, 1'b0);
    end_sim();
  end
endmodule : tsp_port_tb_top
